// ==== hdl/pmcp_defines.vh ====
// Register map, field positions, reset values and timing counts of the power mode block.
`ifndef PMCP_DEFINES_VH
`define PMCP_DEFINES_VH

// Printed register indices; the byte address on the bus is four times the index.
`define PMCP_IDX_POWER_CONTROL   8'h87
`define PMCP_IDX_MODE_STATUS     8'h88
`define PMCP_IDX_CLOCK_RELOAD    8'h97
`define PMCP_ADDR_W              10
`define PMCP_ADDR_POWER_CONTROL  10'h21c
`define PMCP_ADDR_MODE_STATUS    10'h220
`define PMCP_ADDR_CLOCK_RELOAD   10'h25c

// Power control register fields.
`define PMCP_PC_DOUBLE_BAUD      7
`define PMCP_PC_FRAME_ERR_SEL    6
`define PMCP_PC_RESERVED         5
`define PMCP_PC_POWER_OFF        4
`define PMCP_PC_GFLAG_ONE        3
`define PMCP_PC_GFLAG_ZERO       2
`define PMCP_PC_POWERDOWN        1
`define PMCP_PC_IDLE             0

// Mode status register fields.
`define PMCP_MS_STATE_LSB        0
`define PMCP_MS_STATE_MSB        1
`define PMCP_MS_CPU_CLK_ON       2
`define PMCP_MS_PERIPH_CLK_ON    3
`define PMCP_MS_OSC_STOPPED      4
`define PMCP_MS_DOUBLE_SPEED     5

// Reset values.
`define PMCP_RST_POWER_OFF       1'b1
`define PMCP_RST_CLOCK_RELOAD    8'hff

// Prescaler figures.
`define PMCP_RELOAD_TOP          10'd255
`define PMCP_DIV_TOP_SINGLE      10'd2
`define PMCP_DIV_TOP_DOUBLE      10'd1
`define PMCP_DIV_W               10

// Oscillator settle cycles after a wake from power-down.
`define PMCP_OSC_SETTLE_CYCLES   8

`endif

// ==== hdl/pmcp_prescaler.v ====
// Clock prescaler that turns the oscillator clock into a divided tick.
`timescale 1ns/1ps
`include "pmcp_defines.vh"

module pmcp_prescaler (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       osc_run_i,
  input  wire       double_speed_mode_i,
  input  wire [7:0] clock_reload_value_i,
  output wire       tick_o
);

  reg  [`PMCP_DIV_W-1:0] count_reg;
  reg  [`PMCP_DIV_W-1:0] count_next;
  reg                    tick_reg;
  reg                    tick_next;
  reg  [`PMCP_DIV_W-1:0] divisor;
  wire [`PMCP_DIV_W-1:0] span;

  assign span = `PMCP_RELOAD_TOP - {2'b00, clock_reload_value_i};

  // All ones is the fast corner; any other value divides by a multiple of the span.
  always @* begin
    if (clock_reload_value_i == 8'hff) begin
      divisor = double_speed_mode_i ? `PMCP_DIV_TOP_DOUBLE : `PMCP_DIV_TOP_SINGLE;
    end else if (double_speed_mode_i) begin
      divisor = {span[`PMCP_DIV_W-2:0], 1'b0};
    end else begin
      divisor = {span[`PMCP_DIV_W-3:0], 2'b00};
    end
  end

  // A reload written mid-period takes effect at once; the counter never overshoots
  // because the compare is greater-or-equal.
  always @* begin
    count_next = count_reg;
    tick_next  = 1'b0;
    if (!osc_run_i) begin
      count_next = {`PMCP_DIV_W{1'b0}};
    end else if (count_reg >= divisor - 10'd1) begin
      count_next = {`PMCP_DIV_W{1'b0}};
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 10'd1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= {`PMCP_DIV_W{1'b0}};
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// ==== hdl/pmcp_core.v ====
// Power mode control and clock prescaler with a classic Wishbone register slave.
// Notes on behaviour
// - Writing one to the idle request bit enters idle mode, and an interrupt or a reset clears it.
// - Writing one to the powerdown request bit enters power-down, cleared by reset or wake-up.
// - With idle and powerdown requested together the block goes to power-down, not idle.
// - The power off flag is set by a supply rise, held until software clears it, settable too.
// - The double baud select bit doubles the serial baud rate in serial modes 1, 2 and 3.
// - The frame error select bit routes one serial control location to mode bit zero or framing error.
// - A prescaler sits between the oscillator and both the CPU and peripheral clocks, set by the reload.
// - The clock reload value resets to all ones and is written only as a whole byte.
// - After reset the power control register reads zero except the power off flag, which reads one.
// - Below all ones the divide is four or two times 255 minus reload; all ones gives two or one.
// - Power-down stops the oscillator, holds the clocks at known states and keeps all stored state; the prescaler count is cleared to zero instead.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pmcp_defines.vh"

module pmcp_core #(
  parameter OSC_SETTLE_CYCLES = `PMCP_OSC_SETTLE_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // Classic Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Events from the rest of the chip.
  input  wire        supply_rise_i,
  input  wire        interrupt_i,
  input  wire        wakeup_interrupt_i,
  input  wire        double_speed_mode_i,
  // Serial control register location steered by the frame error select bit.
  input  wire        serial_mode_bit_zero_i,
  input  wire        framing_error_bit_i,
  input  wire        serial_loc_we_i,
  output wire        serial_loc_rd_o,
  output wire        serial_mode_bit_zero_we_o,
  output wire        framing_error_bit_we_o,
  // Serial port controls.
  input  wire [1:0]  serial_mode_i,
  output wire        double_baud_o,
  output wire        frame_error_select_o,
  // Clock and mode outputs.
  output wire        cpu_clk_en_o,
  output wire        periph_clk_en_o,
  output wire        osc_stop_o,
  output wire        idle_mode_o,
  output wire        powerdown_mode_o,
  output wire        general_flag_one_o,
  output wire        general_flag_zero_o
);

  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_PDOWN = 2'b10;
  localparam [1:0] ST_WAKE  = 2'b11;

  localparam integer SETTLE_LAST_FULL = OSC_SETTLE_CYCLES - 1;
  localparam [3:0]   SETTLE_LAST      = SETTLE_LAST_FULL[3:0];

  // Power control fields.
  reg        double_baud_select_reg;
  reg        double_baud_select_next;
  reg        frame_error_select_reg;
  reg        frame_error_select_next;
  reg        power_off_flag_reg;
  reg        power_off_flag_next;
  reg        general_flag_one_reg;
  reg        general_flag_one_next;
  reg        general_flag_zero_reg;
  reg        general_flag_zero_next;
  reg        powerdown_request_reg;
  reg        powerdown_request_next;
  reg        idle_request_reg;
  reg        idle_request_next;
  reg  [7:0] clock_reload_value_reg;
  reg  [7:0] clock_reload_value_next;

  // Mode sequencer.
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [3:0] settle_reg;
  reg  [3:0] settle_next;

  // Bus slave.
  reg        ack_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;

  // Gated clock enables, registered so that they never glitch.
  reg        cpu_clk_en_reg;
  reg        periph_clk_en_reg;

  wire       bus_req;
  wire       adr_in_window;
  wire       settle_done;
  wire       bus_wr;
  wire       lane0_wr;
  wire [`PMCP_ADDR_W-1:0] bus_addr;
  wire       hit_power_control;
  wire       hit_clock_reload;
  wire       hit_mode_status;
  wire       pc_wr;
  wire [7:0] power_control_register;
  wire [7:0] mode_status;
  wire       osc_run;
  wire       prescale_tick;
  wire       cpu_clk_on;
  wire       periph_clk_on;

  // Upper address bits above the decoded window must be zero, so aliases stay unmapped.
  assign adr_in_window     = (wb_adr_i[31:`PMCP_ADDR_W] == 22'h000000);
  assign bus_addr          = wb_adr_i[`PMCP_ADDR_W-1:0];
  assign bus_req           = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr            = bus_req & wb_we_i & adr_in_window;
  assign lane0_wr          = bus_wr & wb_sel_i[0];
  assign hit_power_control = (bus_addr == `PMCP_ADDR_POWER_CONTROL);
  assign hit_clock_reload  = (bus_addr == `PMCP_ADDR_CLOCK_RELOAD);
  assign hit_mode_status   = (bus_addr == `PMCP_ADDR_MODE_STATUS);
  assign pc_wr             = lane0_wr & hit_power_control;

  // The reserved bit always reads zero, a defined value software must ignore.
  assign power_control_register = {double_baud_select_reg,
                                   frame_error_select_reg,
                                   1'b0,
                                   power_off_flag_reg,
                                   general_flag_one_reg,
                                   general_flag_zero_reg,
                                   powerdown_request_reg,
                                   idle_request_reg};

  assign mode_status = {2'b00,
                        double_speed_mode_i,
                        ~osc_run,
                        periph_clk_on,
                        cpu_clk_on,
                        state_reg};

  // Software flags and mode bits.
  always @* begin
    double_baud_select_next = double_baud_select_reg;
    frame_error_select_next = frame_error_select_reg;
    general_flag_one_next   = general_flag_one_reg;
    general_flag_zero_next  = general_flag_zero_reg;
    if (pc_wr) begin
      double_baud_select_next = wb_dat_i[`PMCP_PC_DOUBLE_BAUD];
      frame_error_select_next = wb_dat_i[`PMCP_PC_FRAME_ERR_SEL];
      general_flag_one_next   = wb_dat_i[`PMCP_PC_GFLAG_ONE];
      general_flag_zero_next  = wb_dat_i[`PMCP_PC_GFLAG_ZERO];
    end
  end

  // The reload is one byte in lane zero; other lanes carry nothing, so a write that
  // leaves lane zero disabled is ignored rather than splitting the byte.
  always @* begin
    clock_reload_value_next = clock_reload_value_reg;
    if (lane0_wr && hit_clock_reload) begin
      clock_reload_value_next = wb_dat_i[7:0];
    end
  end

  // A supply rise beats a software clear in the same cycle, so it is never lost.
  always @* begin
    power_off_flag_next = power_off_flag_reg;
    if (pc_wr) begin
      power_off_flag_next = wb_dat_i[`PMCP_PC_POWER_OFF];
    end
    if (supply_rise_i) begin
      power_off_flag_next = 1'b1;
    end
  end

  // A request written in the same cycle as a wake event wins: the block then sleeps
  // and the next event wakes it, rather than dropping the write.
  always @* begin
    idle_request_next      = idle_request_reg;
    powerdown_request_next = powerdown_request_reg;
    if (interrupt_i) begin
      idle_request_next = 1'b0;
    end
    if (wakeup_interrupt_i) begin
      powerdown_request_next = 1'b0;
    end
    if (pc_wr) begin
      idle_request_next      = wb_dat_i[`PMCP_PC_IDLE];
      powerdown_request_next = wb_dat_i[`PMCP_PC_POWERDOWN];
    end
  end

  // Mode sequencer; power-down has precedence over idle.
  always @* begin
    state_next  = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      ST_RUN: begin
        if (powerdown_request_reg) begin
          state_next = ST_PDOWN;
        end else if (idle_request_reg) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (powerdown_request_reg) begin
          state_next = ST_PDOWN;
        end else if (!idle_request_reg) begin
          state_next = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (!powerdown_request_reg) begin
          state_next  = ST_WAKE;
          settle_next = 4'h0;
        end
      end
      ST_WAKE: begin
        // The oscillator runs again; the CPU resumes once it has settled and the
        // wake-up source has been released, then enters idle a cycle later if that bit stays set.
        if (!settle_done) begin
          settle_next = settle_reg + 4'h1;
        end else if (!wakeup_interrupt_i) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next  = ST_RUN;
        settle_next = 4'h0;
      end
    endcase
  end

  // The settle count starts at zero, so it is done one short of the parameter.
  assign settle_done   = (settle_reg == SETTLE_LAST);
  assign osc_run       = (state_reg != ST_PDOWN);
  assign periph_clk_on = (state_reg == ST_RUN) | (state_reg == ST_IDLE);
  assign cpu_clk_on    = (state_reg == ST_RUN);

  // Register bus read path; unmapped addresses answer with zero.
  always @* begin
    rdata_next = 32'h00000000;
    if (adr_in_window) begin
      if (hit_power_control) begin
        rdata_next = {24'h000000, power_control_register};
      end else if (hit_clock_reload) begin
        rdata_next = {24'h000000, clock_reload_value_reg};
      end else if (hit_mode_status) begin
        rdata_next = {24'h000000, mode_status};
      end
    end
  end

  // Every register field is cleared or preset by reset, so a reset taken in any mode,
  // power-down included, leaves software with its reset values.
  always @(posedge clk_i) begin
    if (rst_i) begin
      double_baud_select_reg <= 1'b0;
      frame_error_select_reg <= 1'b0;
      power_off_flag_reg     <= `PMCP_RST_POWER_OFF;
      general_flag_one_reg   <= 1'b0;
      general_flag_zero_reg  <= 1'b0;
      powerdown_request_reg  <= 1'b0;
      idle_request_reg       <= 1'b0;
      clock_reload_value_reg <= `PMCP_RST_CLOCK_RELOAD;
    end else begin
      double_baud_select_reg <= double_baud_select_next;
      frame_error_select_reg <= frame_error_select_next;
      power_off_flag_reg     <= power_off_flag_next;
      general_flag_one_reg   <= general_flag_one_next;
      general_flag_zero_reg  <= general_flag_zero_next;
      powerdown_request_reg  <= powerdown_request_next;
      idle_request_reg       <= idle_request_next;
      clock_reload_value_reg <= clock_reload_value_next;
    end
  end

  // Reset always returns the sequencer to run, which also restarts the oscillator.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= ST_RUN;
      settle_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
    end
  end

  // Read data is only loaded when a request is taken, so it holds the last answer
  // and a master that samples it late never sees it change.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // The enables lag the prescaler tick by one cycle; both share that delay, so the
  // CPU and peripheral clocks stay in phase.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_reg    <= 1'b0;
      periph_clk_en_reg <= 1'b0;
    end else begin
      cpu_clk_en_reg    <= prescale_tick & cpu_clk_on;
      periph_clk_en_reg <= prescale_tick & periph_clk_on;
    end
  end

  pmcp_prescaler u_prescaler (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .osc_run_i            (osc_run),
    .double_speed_mode_i  (double_speed_mode_i),
    .clock_reload_value_i (clock_reload_value_reg),
    .tick_o               (prescale_tick)
  );

  // Serial location steering: the same location reaches one of two serial bits.
  assign serial_loc_rd_o = frame_error_select_reg ? framing_error_bit_i
                                                  : serial_mode_bit_zero_i;
  assign serial_mode_bit_zero_we_o = serial_loc_we_i & ~frame_error_select_reg;
  assign framing_error_bit_we_o    = serial_loc_we_i & frame_error_select_reg;

  // Mode 0 has a fixed rate, so doubling only applies in modes 1 to 3.
  assign double_baud_o        = double_baud_select_reg & (serial_mode_i != 2'b00);
  assign frame_error_select_o = frame_error_select_reg;

  assign wb_ack_o            = ack_reg;
  assign wb_dat_o            = rdata_reg;
  assign cpu_clk_en_o        = cpu_clk_en_reg;
  assign periph_clk_en_o     = periph_clk_en_reg;
  assign osc_stop_o          = ~osc_run;
  assign idle_mode_o         = (state_reg == ST_IDLE);
  assign powerdown_mode_o    = (state_reg == ST_PDOWN);
  assign general_flag_one_o  = general_flag_one_reg;
  assign general_flag_zero_o = general_flag_zero_reg;

endmodule

// ==== bench/pmcp_checker.sv ====
// Concurrent checks on the ports of the power mode and prescaler block.
`timescale 1ns/1ps
module pmcp_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        interrupt_i,
  input wire        wakeup_interrupt_i,
  input wire        serial_mode_bit_zero_i,
  input wire        framing_error_bit_i,
  input wire        serial_loc_we_i,
  input wire        serial_loc_rd_o,
  input wire        serial_mode_bit_zero_we_o,
  input wire        framing_error_bit_we_o,
  input wire [1:0]  serial_mode_i,
  input wire        double_baud_o,
  input wire        frame_error_select_o,
  input wire        cpu_clk_en_o,
  input wire        periph_clk_en_o,
  input wire        osc_stop_o,
  input wire        idle_mode_o,
  input wire        powerdown_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr_pc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
               && wb_adr_i == 32'h0000021c;

  chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single pulse after a request");
  chk_idle_entry: assert property (wr_pc && wb_dat_i[1:0] == 2'b01 && !interrupt_i
    && !powerdown_mode_o |-> ##2 idle_mode_o) else $error("idle not entered after write");
  chk_idle_exit: assert property ((interrupt_i && !wb_cyc_i) [*2] |=> !idle_mode_o)
    else $error("idle kept while interrupt present");
  chk_pd_entry: assert property (wr_pc && wb_dat_i[1] && !wakeup_interrupt_i
    |-> ##2 powerdown_mode_o) else $error("power-down not entered after write");
  chk_pd_exit: assert property ((wakeup_interrupt_i && !wb_cyc_i) [*2] |=> !powerdown_mode_o)
    else $error("power-down kept while wake-up present");
  chk_mode_excl: assert property (!(idle_mode_o && powerdown_mode_o))
    else $error("idle and power-down both shown");
  chk_osc_stop: assert property (osc_stop_o == powerdown_mode_o)
    else $error("oscillator stop differs from power-down");
  chk_pd_clocks: assert property ($past(powerdown_mode_o) && powerdown_mode_o
    |-> !cpu_clk_en_o && !periph_clk_en_o) else $error("clock tick in power-down");
  chk_idle_gate: assert property ($past(idle_mode_o) && idle_mode_o |-> !cpu_clk_en_o)
    else $error("cpu tick in idle");
  chk_cpu_periph: assert property (cpu_clk_en_o |-> periph_clk_en_o)
    else $error("cpu tick without peripheral tick");
  chk_baud_gate: assert property (serial_mode_i == 2'b00 |-> !double_baud_o)
    else $error("double baud in serial mode zero");
  chk_serial_route: assert property (serial_loc_rd_o == (frame_error_select_o ?
    framing_error_bit_i : serial_mode_bit_zero_i) && framing_error_bit_we_o ==
    (serial_loc_we_i && frame_error_select_o) && serial_mode_bit_zero_we_o ==
    (serial_loc_we_i && !frame_error_select_o)) else $error("serial location misrouted");

  cov_idle: cover property ($rose(idle_mode_o));
  cov_pd: cover property ($rose(powerdown_mode_o));
  cov_cpu_tick: cover property (cpu_clk_en_o);
endmodule

bind pmcp_core pmcp_checker i_pmcp_checker (.*);

// ==== bench/test_power_mode_and_clock_prescaler.sv ====
// Self-checking bench for the power mode and clock prescaler block.
`timescale 1ns/1ps
`include "pmcp_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR at %0t got %h expected %h", $time, (a), (e)); end end

module test_power_mode_and_clock_prescaler;
  localparam logic [9:0] pc_adr = `PMCP_ADDR_POWER_CONTROL;
  localparam logic [9:0] ck_adr = `PMCP_ADDR_CLOCK_RELOAD;
  localparam logic [9:0] ms_adr = `PMCP_ADDR_MODE_STATUS;
  logic        clk_i = 1'b0;
  logic        rst_i, wb_cyc_i, wb_stb_i, wb_we_i, supply_rise_i, interrupt_i;
  logic        wakeup_interrupt_i, double_speed_mode_i, serial_mode_bit_zero_i;
  logic        framing_error_bit_i, serial_loc_we_i;
  logic [1:0]  serial_mode_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_adr_i, wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, serial_loc_rd_o, serial_mode_bit_zero_we_o, framing_error_bit_we_o;
  wire         double_baud_o, frame_error_select_o, cpu_clk_en_o, periph_clk_en_o;
  wire         osc_stop_o, idle_mode_o, powerdown_mode_o;
  wire         general_flag_one_o, general_flag_zero_o;
  int          fail_count = 0;
  int          comparisons = 0;
  logic [15:0] lfsr = 16'd35455;

  // A short settle keeps the wake-up walk brief.
  pmcp_core #(.OSC_SETTLE_CYCLES(2)) i_pmcp_core (.*);

  always #2 clk_i = ~clk_i;

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int exp_div(input logic [7:0] r, input logic x2);
    if (r == 8'hff) return x2 ? 1 : 2;
    return (x2 ? 2 : 4) * (255 - int'(r));
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // The request is held until ack is seen at a rising edge, then released.
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d,
                    input logic s, output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {22'h0, a};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= {3'b000, s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 1'b1, q);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, 1'b1, q);
    `CHK(q, e)
  endtask

  task automatic measure(output int p);
    int n;
    n = 0;
    p = 0;
    do begin @(posedge clk_i); n++; end while (periph_clk_en_o !== 1'b1 && n < 3000);
    do begin @(posedge clk_i); p++; end while (periph_clk_en_o !== 1'b1 && p < 3000);
  endtask

  task automatic ticks(input int n, output int c, output int p);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk_i);
      c += (cpu_clk_en_o === 1'b1);
      p += (periph_clk_en_o === 1'b1);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    int i, c, p;
    logic [7:0] d, q;
    logic [7:0] rl [5];
    {wb_cyc_i, wb_stb_i, wb_we_i, supply_rise_i, interrupt_i} = '0;
    {wakeup_interrupt_i, double_speed_mode_i, serial_mode_bit_zero_i} = '0;
    {framing_error_bit_i, serial_loc_we_i, serial_mode_i, wb_sel_i} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(pc_adr, 8'h10);
    rd_chk(ck_adr, 8'hff);
    rd_chk(10'h3fc, 8'h00);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      d = {lfsr[7:6], 1'b0, lfsr[4:2], 2'b00};
      wr(ck_adr, lfsr[15:8]);
      wb(1'b1, ck_adr, ~lfsr[15:8], 1'b0, q);
      rd_chk(ck_adr, lfsr[15:8]);
      wr(pc_adr, d);
      rd_chk(pc_adr, d);
      serial_mode_i <= lfsr[9:8];
      framing_error_bit_i <= lfsr[10];
      serial_mode_bit_zero_i <= lfsr[11];
      serial_loc_we_i <= lfsr[12];
      @(negedge clk_i);
      `CHK(double_baud_o, d[7] && lfsr[9:8] != 2'b00)
      `CHK(serial_loc_rd_o, d[6] ? lfsr[10] : lfsr[11])
      `CHK(framing_error_bit_we_o, lfsr[12] & d[6])
      `CHK(serial_mode_bit_zero_we_o, lfsr[12] & ~d[6])
      `CHK(frame_error_select_o, d[6])
      `CHK({general_flag_one_o, general_flag_zero_o}, d[3:2])
    end
    wr(pc_adr, 8'h00);
    supply_rise_i <= 1'b1;
    @(posedge clk_i);
    supply_rise_i <= 1'b0;
    rd_chk(pc_adr, 8'h10);
    $display("register traffic done");
    rl = '{8'hff, 8'hfe, 8'hf0, 8'h00, lfsr[7:0]};
    for (i = 0; i < 10; i++) begin
      wr(ck_adr, rl[i / 2]);
      double_speed_mode_i <= i[0];
      measure(p);
      measure(p);
      `CHK(p, exp_div(rl[i / 2], i[0]))
    end
    wr(ck_adr, 8'hff);
    double_speed_mode_i <= 1'b0;
    $display("prescaler done");
    wr(pc_adr, 8'h01);
    repeat (2) @(posedge clk_i);
    ticks(20, c, p);
    `CHK({idle_mode_o, c == 0, p > 0}, 3'b111)
    rd_chk(ms_adr, 8'h09);
    interrupt_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    interrupt_i <= 1'b0;
    ticks(20, c, p);
    `CHK({idle_mode_o, c > 0}, 2'b01)
    rd_chk(pc_adr, 8'h00);
    $display("idle done");
    wr(ck_adr, 8'hfe);
    wr(pc_adr, 8'h02);
    repeat (2) @(posedge clk_i);
    ticks(20, c, p);
    `CHK({powerdown_mode_o, osc_stop_o, c == 0, p == 0}, 4'hf)
    rd_chk(ms_adr, 8'h12);
    wakeup_interrupt_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wakeup_interrupt_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK(powerdown_mode_o, 1'b0)
    rd_chk(ck_adr, 8'hfe);
    rd_chk(pc_adr, 8'h00);
    $display("power-down done");
    wr(pc_adr, 8'h03);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({powerdown_mode_o, idle_mode_o}, 2'b10)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(powerdown_mode_o, 1'b0)
    rd_chk(pc_adr, 8'h10);
    rd_chk(ck_adr, 8'hff);
    $display("reset in power-down done");
    complete_run();
  end
endmodule
